/* hdl/sbap_pkg.sv */
/*
 * Constants, encodings and register map of the subchannel byte assembly path.
 * Assumes an AHB-Lite master with one slave, a byte-wide control unit interface
 * and a storage port with a one-cycle read latency after grant.
 */
// Functional notes
// - Forward: add two per cycle, toggle bit 31
// - Forward: service only with interface buffer empty
// - Forward: bit 31 set to low register
// - Extend set: buffer transfer waits for cycle
// - Bit 30 selects storage halfword lanes
// - Store a byte register only when valid
// - Forward: request cycle on high register fill
// - Grant: address without bits 30, 31 stored
// - Forward first cycle lanes from byte flags
// - Middle cycles: two lanes channel, two storage
// - Forward last cycle lanes from byte flags
// - Backward: decrement address on every cycle
// - Backward: buffer full when extend, bit 31 clear
// - Backward: bit 31 clear to low register
// - Backward: request after first low, then high
// - Backward first cycle lanes from byte flags
// - Backward last cycle lanes from byte flags
// - End of read stores residual bytes
// - Count zero, full: move, request again
// - Write: regenerate word, bit 30 halfword select
// - Write: request when high register emptied
// - Write: add two, toggle bit 31 per byte
// - Read service decrements byte count

package sbap_pkg;

    // ************************************************************
    // Widths and steps
    // ************************************************************
    localparam int          DA_W      = 24;
    localparam int          CNT_W     = 16;
    localparam int          SA_W      = 22;
    localparam logic [23:0] DA_STEP   = 24'h00_0002;
    localparam logic [23:0] DA_RESET  = 24'h00_0000;
    localparam logic [15:0] CNT_RESET = 16'h0000;

    // ************************************************************
    // Register map (byte addresses, low eight bits decoded)
    // ************************************************************
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_ADDR   = 8'h04;
    localparam logic [7:0] OFF_COUNT  = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_WORD   = 8'h10;

    // Control fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_START    = 2;
    localparam int CTRL_STOP     = 3;

    // Status fields
    localparam int ST_BUSY   = 0;
    localparam int ST_REQ    = 1;
    localparam int ST_EXT    = 2;
    localparam int ST_VLO    = 3;
    localparam int ST_VHI    = 4;
    localparam int ST_BFULL  = 5;
    localparam int ST_END    = 6;
    localparam int ST_ODD    = 7;
    localparam int ST_SVCOUT = 8;

    // AHB encodings
    localparam int          HTRANS_ACTIVE = 1;
    localparam logic [31:0] RDATA_RESET   = 32'h0000_0000;

    // ************************************************************
    // Enumerations
    // ************************************************************
    typedef enum logic [1:0] {
        MODE_IDLE   = 2'b00,
        MODE_RD_FWD = 2'b01,
        MODE_RD_BWD = 2'b10,
        MODE_WRITE  = 2'b11
    } sbap_mode_t;

    typedef enum logic [1:0] {
        CH_IDLE = 2'b00,
        CH_LOAD = 2'b01,
        CH_MOVE = 2'b10,
        CH_ACK  = 2'b11
    } sbap_chan_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DATA = 2'b01,
        ST_WR   = 2'b10
    } sbap_stor_t;

endpackage

/* hdl/sbap_top.sv */
/*
 * Subchannel byte assembly path: read forward, read backward and write data
 * movement between the byte interface and storage, with an AHB-Lite slave.
 * Assumes storage returns read data the cycle after the grant cycle and the
 * control unit holds service in until service out is seen.
 */
`timescale 1ns/1ns

module sbap_top
    import sbap_pkg::*;
(
    input  wire logic               hclk,
    input  wire logic               hresetn,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic      [31:0]        hrdata,
    output logic                    hreadyout,
    output logic                    hresp,
    input  wire logic               service_in,
    input  wire logic               status_in,
    input  wire logic [7:0]         bus_in,
    output logic                    service_out,
    output logic      [7:0]         bus_out,
    output logic                    stor_req,
    input  wire logic               stor_grant,
    output logic      [SA_W-1:0]    stor_addr,
    input  wire logic [31:0]        stor_rdata,
    output logic      [31:0]        stor_wdata,
    output logic                    stor_we
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [2:0]        svc_s;
        logic [2:0]        sts_s;
        logic [7:0]        bi_s1;
        logic [7:0]        bi_s2;
        logic [7:0]        bi_s3;
        logic              svc_f;
        logic              sts_f;
        sbap_mode_t        mode;
        sbap_chan_t        chan;
        sbap_stor_t        stor;
        logic [DA_W-1:0]   data_address_reg;
        logic [CNT_W-1:0]  cnt;
        logic [7:0]        low_data_byte_reg;
        logic [7:0]        high_data_byte_reg;
        logic [7:0]        interface_byte_buffer;
        logic              v_lo;
        logic              v_hi;
        logic              buf_full;
        logic              req;
        logic              ext;
        logic              odd;
        logic              end_rd;
        logic              first_bwd;
        logic [SA_W-1:0]   storage_address_reg;
        logic [31:0]       storage_word_reg;
        logic              we;
        logic [7:0]        bus_out;
        logic              svc_out;
        logic              ap_valid;
        logic              ap_write;
        logic [7:0]        ap_addr;
        logic [31:0]       rdata;
    } sbap_state_t;

    sbap_state_t q;
    sbap_state_t d;

    localparam sbap_state_t STATE_RESET = '{
        svc_s: 3'b000, sts_s: 3'b000, bi_s1: 8'h00, bi_s2: 8'h00, bi_s3: 8'h00,
        svc_f: 1'b0, sts_f: 1'b0, mode: MODE_IDLE, chan: CH_IDLE, stor: ST_IDLE,
        data_address_reg: DA_RESET, cnt: CNT_RESET,
        low_data_byte_reg: 8'h00, high_data_byte_reg: 8'h00, interface_byte_buffer: 8'h00,
        v_lo: 1'b0, v_hi: 1'b0, buf_full: 1'b0, req: 1'b0, ext: 1'b0, odd: 1'b1,
        end_rd: 1'b0, first_bwd: 1'b1, storage_address_reg: 22'h00_0000,
        storage_word_reg: 32'h0000_0000, we: 1'b0, bus_out: 8'h00, svc_out: 1'b0,
        ap_valid: 1'b0, ap_write: 1'b0, ap_addr: 8'h00, rdata: RDATA_RESET
    };

    // ************************************************************
    // Next state
    // ************************************************************

    // Decides whether a byte entering a data register asks for a cycle
    function automatic logic move_requests(input logic fwd, input logic to_lo, input logic first);
        move_requests = fwd ? !to_lo : (to_lo ? first : 1'b1);
    endfunction

    always_comb begin
        logic        is_rd;
        logic        fwd;
        logic        wr;
        logic        a31;
        logic        a30;
        logic        ibuf_empty;
        logic        to_lo;
        logic [1:0]  lane_lo;
        logic [1:0]  lane_hi;
        logic [31:0] word;
        logic [31:0] status;
        is_rd      = 1'b0;
        fwd        = 1'b0;
        wr         = 1'b0;
        a31        = 1'b0;
        a30        = 1'b0;
        ibuf_empty = 1'b0;
        to_lo      = 1'b0;
        lane_lo    = 2'd0;
        lane_hi    = 2'd1;
        word       = 32'h0000_0000;
        status     = 32'h0000_0000;
        d          = q;

        // Pin synchronisers; a change counts once stages two and three agree
        d.svc_s = {q.svc_s[1:0], service_in};
        d.sts_s = {q.sts_s[1:0], status_in};
        d.bi_s1 = bus_in;
        d.bi_s2 = q.bi_s1;
        d.bi_s3 = q.bi_s2;
        if (q.svc_s[1] == q.svc_s[2]) begin
            d.svc_f = q.svc_s[2];
        end
        if (q.sts_s[1] == q.sts_s[2]) begin
            d.sts_f = q.sts_s[2];
        end

        // Mode decode and steering bits
        is_rd   = (q.mode == MODE_RD_FWD) || (q.mode == MODE_RD_BWD);
        fwd     = (q.mode == MODE_RD_FWD);
        wr      = (q.mode == MODE_WRITE);
        a31     = q.data_address_reg[0];
        a30     = q.data_address_reg[1];
        ibuf_empty = fwd ? !(q.ext && a31) : !(q.ext && !a31);
        to_lo   = fwd ? a31 : !a31;
        lane_lo = a30 ? 2'd2 : 2'd0;
        lane_hi = a30 ? 2'd3 : 2'd1;

        // Storage cycle sequencer
        d.we = 1'b0;
        case (q.stor)
            ST_IDLE: begin
                if (q.req && stor_grant) begin
                    d.storage_address_reg = q.data_address_reg[DA_W-1:2];
                    d.req  = 1'b0;
                    d.stor = ST_DATA;
                end
            end
            ST_DATA: begin
                word = stor_rdata;
                if (is_rd) begin
                    // Lanes follow the byte flags on first, middle and last cycles
                    if (q.v_lo) begin
                        word[31-8*lane_lo -: 8] = q.low_data_byte_reg;
                    end
                    if (q.v_hi) begin
                        word[31-8*lane_hi -: 8] = q.high_data_byte_reg;
                    end
                    d.v_lo = 1'b0;
                    d.v_hi = 1'b0;
                    d.ext  = 1'b0;
                    d.data_address_reg = fwd ? q.data_address_reg + DA_STEP
                                             : q.data_address_reg - DA_STEP;
                    // Buffer held back by extend moves during the cycle
                    if (q.buf_full) begin
                        d.buf_full = 1'b0;
                        if (to_lo) begin
                            d.low_data_byte_reg = q.interface_byte_buffer;
                            d.v_lo = 1'b1;
                        end else begin
                            d.high_data_byte_reg = q.interface_byte_buffer;
                            d.v_hi = 1'b1;
                        end
                        if (q.end_rd || q.cnt == CNT_RESET) begin
                            d.req = 1'b1;
                            d.ext = 1'b1;
                            d.odd = 1'b0;
                        end else if (move_requests(fwd, to_lo, q.first_bwd)) begin
                            d.req = 1'b1;
                            d.ext = 1'b1;
                        end
                        if (to_lo) begin
                            d.first_bwd = 1'b0;
                        end
                    end
                end else begin
                    // Write fetch: whole word written back, halfword to data registers
                    d.low_data_byte_reg  = stor_rdata[31-16*a30 -: 8];
                    d.high_data_byte_reg = stor_rdata[23-16*a30 -: 8];
                    d.v_lo = 1'b1;
                    d.v_hi = 1'b1;
                    d.data_address_reg = q.data_address_reg + DA_STEP;
                end
                d.storage_word_reg = word;
                d.we   = (q.mode != MODE_IDLE);
                d.stor = ST_WR;
            end
            ST_WR: begin
                d.stor = ST_IDLE;
            end
            default: begin
                d.stor = ST_IDLE;
            end
        endcase

        // Write: keep the interface buffer full from the data registers
        if (wr && !q.buf_full && q.chan != CH_LOAD && q.stor != ST_DATA && (q.v_lo || q.v_hi)) begin
            d.buf_full = 1'b1;
            if (a31) begin
                d.interface_byte_buffer = q.high_data_byte_reg;
                d.v_lo = 1'b0;
                d.v_hi = 1'b0;
                d.odd  = 1'b0;
                if (q.cnt != CNT_RESET) begin
                    d.req = 1'b1;
                end
            end else begin
                d.interface_byte_buffer = q.low_data_byte_reg;
                d.v_lo = 1'b0;
            end
        end

        // Channel service sequencer
        case (q.chan)
            CH_IDLE: begin
                if (is_rd && q.svc_f && ibuf_empty && q.cnt != CNT_RESET && !q.end_rd) begin
                    d.chan = CH_LOAD;
                end else if (wr && q.svc_f && q.buf_full && q.cnt != CNT_RESET) begin
                    d.chan = CH_LOAD;
                end
            end
            CH_LOAD: begin
                d.data_address_reg[0] = ~d.data_address_reg[0];
                d.cnt     = q.cnt - 16'h0001;
                d.svc_out = 1'b1;
                if (wr) begin
                    d.bus_out  = q.interface_byte_buffer;
                    d.buf_full = 1'b0;
                    d.chan     = CH_ACK;
                end else begin
                    d.interface_byte_buffer = q.bi_s3;
                    d.buf_full = 1'b1;
                    d.chan     = CH_MOVE;
                end
            end
            CH_MOVE: begin
                if (q.stor != ST_DATA) begin
                    d.chan = CH_ACK;
                    if (!q.ext) begin
                        d.buf_full = 1'b0;
                        if (to_lo) begin
                            d.low_data_byte_reg = q.interface_byte_buffer;
                            d.v_lo = 1'b1;
                            d.first_bwd = 1'b0;
                        end else begin
                            d.high_data_byte_reg = q.interface_byte_buffer;
                            d.v_hi = 1'b1;
                        end
                        if (move_requests(fwd, to_lo, q.first_bwd) || q.cnt == CNT_RESET) begin
                            d.req = 1'b1;
                            d.ext = 1'b1;
                        end
                    end
                end
            end
            CH_ACK: begin
                if (!q.svc_f) begin
                    d.svc_out = 1'b0;
                    d.chan    = CH_IDLE;
                end
            end
            default: begin
                d.chan = CH_IDLE;
            end
        endcase

        // End of read by count or status byte; residual bytes get a cycle
        if (is_rd && (q.sts_f || q.cnt == CNT_RESET)) begin
            d.end_rd = 1'b1;
        end
        if (is_rd && q.end_rd && q.chan == CH_IDLE && q.stor == ST_IDLE && !q.req && !q.ext
            && (q.v_lo || q.v_hi)) begin
            d.req = 1'b1;
            d.ext = 1'b1;
        end

        // AHB address phase and registered read data
        status = 32'h0000_0000;
        status[ST_BUSY]   = (q.mode != MODE_IDLE);
        status[ST_REQ]    = q.req;
        status[ST_EXT]    = q.ext;
        status[ST_VLO]    = q.v_lo;
        status[ST_VHI]    = q.v_hi;
        status[ST_BFULL]  = q.buf_full;
        status[ST_END]    = q.end_rd;
        status[ST_ODD]    = q.odd;
        status[ST_SVCOUT] = q.svc_out;
        d.ap_valid = 1'b0;
        if (hsel && hready && htrans[HTRANS_ACTIVE]) begin
            d.ap_valid = 1'b1;
            d.ap_write = hwrite;
            d.ap_addr  = haddr[7:0];
            if (haddr[7:0] == OFF_CTRL) begin
                d.rdata = {30'h0000_0000, q.mode};
            end else if (haddr[7:0] == OFF_ADDR) begin
                d.rdata = {8'h00, q.data_address_reg};
            end else if (haddr[7:0] == OFF_COUNT) begin
                d.rdata = {16'h0000, q.cnt};
            end else if (haddr[7:0] == OFF_STATUS) begin
                d.rdata = status;
            end else if (haddr[7:0] == OFF_WORD) begin
                d.rdata = q.storage_word_reg;
            end else begin
                d.rdata = RDATA_RESET;
            end
        end

        // AHB data phase writes
        if (q.ap_valid && q.ap_write) begin
            if (q.ap_addr == OFF_CTRL) begin
                if (hwdata[CTRL_STOP]) begin
                    d.mode = MODE_IDLE;
                    d.req  = 1'b0;
                end else if (hwdata[CTRL_START]) begin
                    d.mode      = sbap_mode_t'(hwdata[CTRL_MODE_LSB +: 2]);
                    d.chan      = CH_IDLE;
                    d.v_lo      = 1'b0;
                    d.v_hi      = 1'b0;
                    d.buf_full  = 1'b0;
                    d.ext       = 1'b0;
                    d.end_rd    = 1'b0;
                    d.odd       = 1'b1;
                    d.first_bwd = 1'b1;
                    d.svc_out   = 1'b0;
                    d.req       = (hwdata[CTRL_MODE_LSB +: 2] == MODE_WRITE);
                end
            end else if (q.ap_addr == OFF_ADDR) begin
                d.data_address_reg = hwdata[DA_W-1:0];
            end else if (q.ap_addr == OFF_COUNT) begin
                d.cnt = hwdata[CNT_W-1:0];
            end
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= STATE_RESET;
        end else begin
            q <= d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign hrdata      = q.rdata;
    assign hreadyout   = 1'b1;
    assign hresp       = 1'b0;
    assign service_out = q.svc_out;
    assign bus_out     = q.bus_out;
    assign stor_req    = q.req && (q.stor == ST_IDLE);
    assign stor_addr   = q.storage_address_reg;
    assign stor_wdata  = q.storage_word_reg;
    assign stor_we     = q.we;

endmodule

/* testbench/sbap_monitor.sv */
/* Port checker for sbap_top: storage cycle and handshake timing.
   Assumes one clock, hresetn active low; bound below. */
`timescale 1ns/1ns
module sbap_monitor
    import sbap_pkg::*;
(
    input wire logic            hclk,
    input wire logic            hresetn,
    input wire logic            hreadyout,
    input wire logic            hresp,
    input wire logic            service_in,
    input wire logic            service_out,
    input wire logic [7:0]      bus_out,
    input wire logic            stor_req,
    input wire logic            stor_grant,
    input wire logic [SA_W-1:0] stor_addr,
    input wire logic            stor_we
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ************************************************************
    // Assertions
    // ************************************************************
    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("Bus answer not ready or not okay");
    AST_WB_AFTER_GRANT: assert property (stor_req && stor_grant |-> ##2 stor_we)
        else $error("No write back two cycles after grant");
    AST_WB_ADDR_HELD: assert property (stor_we |-> $stable(stor_addr))
        else $error("Storage address moved during cycle");
    AST_WB_PULSE: assert property (stor_we |=> !stor_we)
        else $error("Write pulse longer than one cycle");
    AST_REQ_DROPS: assert property (stor_req && stor_grant |=> !stor_req [*2])
        else $error("Request held after grant");
    AST_SVC_CAUSE: assert property ($rose(service_out) |-> $past(service_in) && $past(service_in, 2))
        else $error("Service out without service in");
    AST_SVC_HOLD: assert property (service_out && service_in |=> service_out)
        else $error("Service out dropped early");
    AST_SVC_RELEASE: assert property ($fell(service_out) |-> !$past(service_in) && !$past(service_in, 2))
        else $error("Service out fell too soon");
    AST_OUT_STABLE: assert property (service_out && $past(service_out) |-> $stable(bus_out))
        else $error("Outbound byte moved during service");

    // Main scenario coverage
    COV_GRANT: cover property (stor_req && stor_grant);
    COV_WB: cover property (stor_we);
    COV_SVC: cover property ($rose(service_out));
endmodule

bind sbap_top sbap_monitor mon (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .service_in(service_in), .service_out(service_out), .bus_out(bus_out), .stor_req(stor_req),
    .stor_grant(stor_grant), .stor_addr(stor_addr), .stor_we(stor_we));

/* testbench/sbap_cu_model.sv */
/* Control unit model on the byte interface.
   Assumes the bench calls its tasks after a rising edge. */
`timescale 1ns/1ns
module sbap_cu_model (
    input  wire logic       hclk,
    input  wire logic       service_out,
    input  wire logic [7:0] bus_out,
    output logic            service_in,
    output logic            status_in,
    output logic [7:0]      bus_in
);
    initial begin
        service_in = 1'b0;
        status_in  = 1'b0;
        bus_in     = 8'h00;
    end

    // One byte each way; bus shows inverse once released
    task automatic xfer(input logic [7:0] b, input int gap, output logic [7:0] got, output logic ok);
        int n;
        n = 0;
        repeat (gap) @(posedge hclk);
        bus_in <= b;
        @(posedge hclk);
        service_in <= 1'b1;
        do begin
            @(posedge hclk);
            n++;
        end while (service_out !== 1'b1 && n < 60);
        got = bus_out;
        service_in <= 1'b0;
        bus_in     <= ~b;
        do begin
            @(posedge hclk);
            n++;
        end while (service_out !== 1'b0 && n < 120);
        ok = (n < 60);
    endtask

    // Status byte ends a read
    task automatic status_pulse();
        @(posedge hclk);
        status_in <= 1'b1;
        repeat (6) @(posedge hclk);
        status_in <= 1'b0;
    endtask
endmodule

/* testbench/test_subchannel_byte_assembly_path.sv */
/* Bench for sbap_top: AHB master, storage model, scenarios.
   Assumes the control unit model and the bound checker. */
`timescale 1ns/1ns
module test_subchannel_byte_assembly_path;
    import sbap_pkg::*;
    localparam logic [31:0] BG = 32'hf0f1_f2f3;
    logic            hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0]     haddr, hwdata, hrdata, stor_rdata, stor_wdata;
    logic [1:0]      htrans;
    logic [2:0]      hsize;
    logic            service_in, status_in, service_out, stor_req, stor_grant, stor_we;
    logic [7:0]      bus_in, bus_out;
    logic [SA_W-1:0] stor_addr;
    logic [31:0]     mem [0:31];
    int              fails = 0, checks_done = 0, cycles = 0;

    assign hready     = hreadyout;
    assign stor_rdata = mem[stor_addr[4:0]];

    sbap_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .service_in(service_in), .status_in(status_in),
        .bus_in(bus_in), .service_out(service_out), .bus_out(bus_out), .stor_req(stor_req),
        .stor_grant(stor_grant), .stor_addr(stor_addr), .stor_rdata(stor_rdata),
        .stor_wdata(stor_wdata), .stor_we(stor_we));
    sbap_cu_model cu (.hclk(hclk), .service_out(service_out), .bus_out(bus_out),
        .service_in(service_in), .status_in(status_in), .bus_in(bus_in));

    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    // Storage: grant a cycle after request, write on pulse
    always @(posedge hclk) begin
        stor_grant <= stor_req & ~stor_grant;
        if (stor_we === 1'b1) mem[stor_addr[4:0]] <= stor_wdata;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            conclude();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        if (fails == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ************************************************************
    // AHB master and helpers
    // ************************************************************
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= {24'h00_0000, a};
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask

    task automatic start(input logic [1:0] m, input logic [31:0] a, n);
        logic [31:0] r;
        ahb(1'b1, OFF_ADDR, a, r);
        ahb(1'b1, OFF_COUNT, n, r);
        ahb(1'b1, OFF_CTRL, {28'h000_0000, 2'b01, m}, r);
    endtask

    // Wait until request and extend latches clear, then the write back
    task automatic settle();
        logic [31:0] s;
        int n;
        n = 0;
        do begin
            ahb(1'b0, OFF_STATUS, 32'h0000_0000, s);
            n++;
        end while ((s & 32'h0000_0006) != 0 && n < 40);
        repeat (4) @(posedge hclk);
    endtask

    task automatic send(input logic [7:0] b, input int gap);
        logic [7:0] g;
        logic ok;
        cu.xfer(b, gap, g, ok);
        check("handshake", {31'h0000_0000, ok}, 32'h0000_0001);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_regs();
        logic [31:0] r;
        ahb(1'b0, OFF_CTRL, 32'h0000_0000, r);
        check("ctrl reset", r, 32'h0000_0000);
        ahb(1'b0, OFF_STATUS, 32'h0000_0000, r);
        check("status reset", r, 32'h0000_0080);
        ahb(1'b0, 8'h20, 32'h0000_0000, r);
        check("unmapped", r, 32'h0000_0000);
        ahb(1'b1, OFF_ADDR, 32'hffff_ffff, r);
        ahb(1'b0, OFF_ADDR, 32'h0000_0000, r);
        check("addr width", r, 32'h00ff_ffff);
    endtask

    task automatic t_reads();
        logic [31:0] r;
        start(MODE_RD_FWD, 32'h0000_0000, 32'h0000_0004);
        send(8'h11, 0);
        send(8'h22, 0);
        send(8'h33, 5);
        send(8'h44, 0);
        settle();
        check("fwd word", mem[0], 32'h1122_3344);
        ahb(1'b0, OFF_WORD, 32'h0000_0000, r);
        check("fwd sdr", r, 32'h1122_3344);
        ahb(1'b0, OFF_COUNT, 32'h0000_0000, r);
        check("fwd count", r, 32'h0000_0000);
        start(MODE_RD_FWD, 32'h0000_0005, 32'h0000_0002);
        send(8'h55, 0);
        send(8'h66, 3);
        settle();
        check("fwd odd word", mem[1], 32'hf055_66f3);
        start(MODE_RD_BWD, 32'h0000_000b, 32'h0000_0002);
        send(8'h77, 0);
        send(8'h88, 0);
        settle();
        check("bwd word", mem[2], 32'hf088_77f3);
        start(MODE_RD_FWD, 32'h0000_0060, 32'h0000_0004);
        send(8'h9a, 0);
        cu.status_pulse();
        settle();
        check("status end word", mem[24], 32'h9af1_f2f3);
        ahb(1'b0, OFF_COUNT, 32'h0000_0000, r);
        check("status end count", r, 32'h0000_0003);
    endtask

    task automatic t_write();
        logic [7:0] g;
        logic ok;
        logic [31:0] r;
        logic [7:0] exp [3] = '{8'h22, 8'h33, 8'h44};
        start(MODE_WRITE, 32'h0000_0041, 32'h0000_0003);
        for (int i = 0; i < 3; i++) begin
            cu.xfer(8'h00, i * 3, g, ok);
            check("write byte", {24'h00_0000, g}, {24'h00_0000, exp[i]});
        end
        settle();
        check("write regen", mem[16], 32'h1122_3344);
        ahb(1'b1, OFF_CTRL, 32'h0000_0008, r);
        ahb(1'b0, OFF_CTRL, 32'h0000_0000, r);
        check("stop mode", r, 32'h0000_0000);
    endtask

    initial begin
        hresetn = 1'b0;
        hsel    = 1'b0;
        htrans  = 2'b00;
        hwrite  = 1'b0;
        hsize   = 3'b010;
        haddr   = 32'h0000_0000;
        hwdata  = 32'h0000_0000;
        for (int i = 0; i < 32; i++) mem[i] = BG;
        mem[16] = 32'h1122_3344;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_reads();
        t_write();
        conclude();
    end
endmodule
